// [src/eepc_guard.sv]
// block protection decode for one array address, bus, latched or per-cell
`timescale 1ns/10ps
module eepc_guard
	import eepc_pkg::*;
(
	input  wire logic        big_array_i,
	input  wire logic [3:0]  base_sel_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [3:0]  guard_i,
	output logic             in_array_o,
	output logic             blocked_o,
	output logic [10:0]      index_o
);
	logic [11:0] low;
	logic [3:0]  blk;

	assign low = addr_i[11:0];

	always_comb
	begin
		blk = 4'h0;
		in_array_o = 1'b0;
		index_o = 11'h000;
		if (big_array_i)
		begin
			// four 512-byte quarters, high nibble from the options cell
			in_array_o = (addr_i[15:12] == base_sel_i) && (low >= BIG_ARRAY_LOW);
			index_o = low[10:0];
			blk[low[10:9]] = 1'b1;
		end
		else
		begin
			in_array_o = (addr_i[15:12] == STD_HI_NIBBLE) &&
				(low >= STD_ARRAY_LOW) && (low <= STD_ARRAY_TOP);
			index_o = {2'b00, low[8:0] - STD_ARRAY_LOW[8:0]};
			if (low < STD_B1_LOW)
				blk[0] = 1'b1;
			else if (low < STD_B2_LOW)
				blk[1] = 1'b1;
			else if (low < STD_B3_LOW)
				blk[2] = 1'b1;
			else
				blk[3] = 1'b1;
		end
	end

	assign blocked_o = |(blk & guard_i);

endmodule

// [src/eepc_opt_cell.sv]
// nonvolatile system-options cell
`timescale 1ns/10ps
module eepc_opt_cell
	import eepc_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clk_en_i,
	input  wire logic       erase_i,
	input  wire logic       program_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      value_o
);
	// cell is nonvolatile: reset leaves it alone, it has its own power-on value
	logic [7:0] cell_q = OPTIONS_RESET;
	logic [7:0] cell_d;

	always_comb
	begin
		cell_d = cell_q;
		if (erase_i)
			cell_d = ERASED_BYTE;
		else if (program_i)
			cell_d = cell_q & data_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (clk_en_i && !rst_i)
			cell_q <= cell_d;
	end

	assign value_o = cell_q;

endmodule

// [src/eepc_pkg.sv]
// constants and types for the array program/erase controller
package eepc_pkg;

	// ----------------------------------------------------------------
	// register map and layouts
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_CTRL       = 16'h103B;
	localparam logic [15:0] ADDR_PROTECT    = 16'h1035;
	localparam logic [15:0] ADDR_OPTIONS    = 16'h103F;
	localparam logic [15:0] ADDR_ARRAY_STD  = 16'hB600;
	localparam logic [3:0]  STD_HI_NIBBLE   = 4'hB;
	localparam logic [11:0] STD_ARRAY_LOW   = 12'h600;
	localparam logic [11:0] STD_ARRAY_TOP   = 12'h7FF;
	localparam logic [11:0] BIG_ARRAY_LOW   = 12'h800;
	localparam logic [11:0] STD_B1_LOW      = 12'h620;
	localparam logic [11:0] STD_B2_LOW      = 12'h660;
	localparam logic [11:0] STD_B3_LOW      = 12'h6E0;

	localparam int CTL_BYTE  = 4;
	localparam int CTL_ROW   = 3;
	localparam int CTL_ERASE = 2;
	localparam int CTL_LATCH = 1;
	localparam int CTL_HV    = 0;
	localparam int CTL_ODD   = 7;
	localparam int CTL_EVEN  = 6;
	localparam int CTL_OTP   = 5;
	localparam int PROT_OPT  = 4;

	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] PROTECT_RESET = 8'h1F;
	localparam logic [7:0] PROTECT_MASK  = 8'h1F;
	localparam logic [7:0] ERASED_BYTE   = 8'hFF;
	localparam logic [7:0] OPTIONS_RESET = 8'hFF;

	// ----------------------------------------------------------------
	// sizes and timing
	// ----------------------------------------------------------------
	localparam int STD_DEPTH      = 512;
	localparam int BIG_DEPTH      = 2048;
	localparam int ROW_BYTES      = 16;
	localparam int OPEN_CYCLES    = 64;
	localparam logic [6:0] OPEN_COUNT = 7'd64;

	typedef enum logic [1:0] {
		EEPC_ERASE_BULK,
		EEPC_ERASE_ROW,
		EEPC_ERASE_BYTE
	} eepc_erase_e;

endpackage

// [src/eepc_top.sv]
// program/erase control for the byte-wide nonvolatile array
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module eepc_top
	import eepc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        clk_en_i,
	input  wire logic        big_array_i,
	input  wire logic        special_mode_i,
	input  wire logic        security_i,
	input  wire logic        single_chip_i,
	input  wire logic        shared_ctrl_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [7:0]       rdata_o,
	output logic             hv_on_o,
	output logic             modes_ok_o
);
	import eepc_pkg::*;

	// ----------------------------------------------------------------
	// storage and decode
	// ----------------------------------------------------------------
	logic [7:0]  mem_q [BIG_DEPTH] = '{default: ERASED_BYTE};
	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [7:0]  prot_q;
	logic [7:0]  prot_d;
	logic [6:0]  open_q;
	logic [6:0]  open_d;
	logic [15:0] laddr_q;
	logic [15:0] laddr_d;
	logic [7:0]  ldata_q;
	logic [7:0]  ldata_d;
	logic        lvalid_q;
	logic        lvalid_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic [7:0]  opt_val;
	logic        bus_in_array;
	logic        bus_blocked;
	logic [10:0] bus_index;
	logic        lat_in_array;
	logic        lat_blocked;
	logic [10:0] lat_index;
	logic        lat_is_opt;
	logic        hv;
	logic        erasing;
	logic        opt_erase;
	logic        opt_prog;
	logic        prog_fire;
	logic        hv_rise;
	eepc_erase_e mode;
	logic [11:0] limit;

	assign hv       = ctrl_q[CTL_HV];
	assign erasing  = ctrl_q[CTL_ERASE];
	// 2048 needs twelve bits; an 11-bit limit would wrap to zero
	assign limit    = big_array_i ? 12'(BIG_DEPTH) : 12'(STD_DEPTH);

	eepc_guard u_bus_guard (
		.big_array_i (big_array_i),
		.base_sel_i  (opt_val[7:4]),
		.addr_i      (addr_i),
		.guard_i     (prot_q[3:0]),
		.in_array_o  (bus_in_array),
		.blocked_o   (bus_blocked),
		.index_o     (bus_index)
	);

	eepc_guard u_lat_guard (
		.big_array_i (big_array_i),
		.base_sel_i  (opt_val[7:4]),
		.addr_i      (laddr_q),
		.guard_i     (prot_q[3:0]),
		.in_array_o  (lat_in_array),
		.blocked_o   (lat_blocked),
		.index_o     (lat_index)
	);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_i && addr_i == ADDR_CTRL)
		begin
			ctrl_d = wdata_i;
			// voltage bit may only change while a latch bit is already set
			if (!(ctrl_q[CTL_LATCH] || ctrl_q[CTL_OTP]))
				ctrl_d[CTL_HV] = 1'b0;
			// latch bits are frozen while the voltage is on
			if (hv)
			begin
				ctrl_d[CTL_LATCH] = ctrl_q[CTL_LATCH];
				ctrl_d[CTL_OTP] = ctrl_q[CTL_OTP];
			end
			if (!hv && !ctrl_q[CTL_LATCH] && wdata_i[CTL_LATCH] && wdata_i[CTL_HV])
			begin
				ctrl_d[CTL_LATCH] = 1'b0;
				ctrl_d[CTL_HV] = 1'b0;
			end
			if (shared_ctrl_i && ctrl_d[CTL_LATCH] && ctrl_d[CTL_OTP])
				ctrl_d[CTL_OTP] = 1'b0;
			if (wdata_i == CTRL_RESET)
				ctrl_d = CTRL_RESET;
		end
	end

	// ----------------------------------------------------------------
	// protect register and open window after reset
	// ----------------------------------------------------------------
	always_comb
	begin
		prot_d = prot_q;
		open_d = open_q;
		if (open_q != OPEN_COUNT)
			open_d = open_q + 7'd1;
		if (wr_i && addr_i == ADDR_PROTECT)
		begin
			if (special_mode_i || open_q != OPEN_COUNT)
				prot_d = wdata_i & PROTECT_MASK;
			else
				prot_d = (prot_q | wdata_i) & PROTECT_MASK;
		end
	end

	// ----------------------------------------------------------------
	// address/data latch and read path
	// ----------------------------------------------------------------
	assign lat_is_opt = (laddr_q == ADDR_OPTIONS);

	always_comb
	begin
		laddr_d  = laddr_q;
		ldata_d  = ldata_q;
		lvalid_d = lvalid_q;
		if (wr_i && ctrl_q[CTL_LATCH] && !hv &&
			(bus_in_array || addr_i == ADDR_OPTIONS))
		begin
			laddr_d  = addr_i;
			ldata_d  = wdata_i;
			lvalid_d = 1'b1;
		end
		if (!ctrl_q[CTL_LATCH])
			lvalid_d = 1'b0;
		rdata_d = 8'h00;
		if (rd_i)
		begin
			if (addr_i == ADDR_CTRL)
				rdata_d = ctrl_q;
			else if (addr_i == ADDR_PROTECT)
				rdata_d = prot_q;
			else if (addr_i == ADDR_OPTIONS)
				rdata_d = opt_val;
			else if (bus_in_array && !ctrl_q[CTL_LATCH] && {1'b0, bus_index} < limit)
				rdata_d = mem_q[bus_index];
		end
	end

	// ----------------------------------------------------------------
	// program/erase action on voltage turn-on
	// ----------------------------------------------------------------
	// action happens once on the voltage edge; software owns the hold time
	assign hv_rise = clk_en_i && !rst_i && !hv && ctrl_d[CTL_HV] && ctrl_q[CTL_LATCH];

	always_comb
	begin
		if (ctrl_q[CTL_BYTE])
			mode = EEPC_ERASE_BYTE;
		else if (ctrl_q[CTL_ROW])
			mode = EEPC_ERASE_ROW;
		else
			mode = EEPC_ERASE_BULK;
	end

	assign prog_fire = hv_rise && lvalid_q;
	assign opt_erase = prog_fire && lat_is_opt && erasing && !prot_q[PROT_OPT] &&
		mode != EEPC_ERASE_BULK;
	assign opt_prog  = prog_fire && lat_is_opt && !erasing && !prot_q[PROT_OPT];

	eepc_opt_cell u_opt (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		.erase_i   (opt_erase),
		.program_i (opt_prog),
		.data_i    (ldata_q),
		.value_o   (opt_val)
	);

	genvar gi;
	generate
		for (gi = 0; gi < BIG_DEPTH; gi++)
		begin : g_cell
			logic [15:0] cell_addr;
			logic        cell_blk;
			logic        hit;
			eepc_guard u_g (
				.big_array_i (big_array_i),
				.base_sel_i  (opt_val[7:4]),
				.addr_i      (cell_addr),
				.guard_i     (prot_q[3:0]),
				.in_array_o  (),
				.blocked_o   (cell_blk),
				.index_o     ()
			);
			assign cell_addr = big_array_i ?
				{opt_val[7:4], 12'(BIG_ARRAY_LOW + 12'(gi))} :
				(ADDR_ARRAY_STD + 16'(gi % STD_DEPTH));
			always_comb
			begin
				hit = 1'b0;
				if (prog_fire && lat_in_array && !cell_blk && gi < limit)
				begin
					unique case (mode)
						EEPC_ERASE_BULK: hit = 1'b1;
						EEPC_ERASE_ROW:  hit = (11'(gi) / 11'(ROW_BYTES)) ==
							(lat_index / 11'(ROW_BYTES));
						EEPC_ERASE_BYTE: hit = (11'(gi) == lat_index);
					endcase
				end
			end
			always_ff @(posedge ref_clk_i)
			begin
				if (hit && erasing)
					mem_q[gi] <= ERASED_BYTE;
				else if (prog_fire && !erasing && lat_in_array && !lat_blocked &&
					11'(gi) == lat_index)
					mem_q[gi] <= mem_q[gi] & ldata_q;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q   <= CTRL_RESET;
			prot_q   <= PROTECT_RESET;
			open_q   <= 7'd0;
			laddr_q  <= 16'h0000;
			ldata_q  <= 8'h00;
			lvalid_q <= 1'b0;
			rdata_q  <= 8'h00;
		end
		else if (clk_en_i)
		begin
			ctrl_q   <= ctrl_d;
			prot_q   <= prot_d;
			open_q   <= open_d;
			laddr_q  <= laddr_d;
			ldata_q  <= ldata_d;
			lvalid_q <= lvalid_d;
			rdata_q  <= rdata_d;
		end
	end

	assign rdata_o    = rdata_q;
	assign hv_on_o    = hv;
	assign modes_ok_o = !security_i || single_chip_i;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_no_dual_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_i && addr_i == ADDR_CTRL && !hv && !ctrl_q[CTL_LATCH] &&
		wdata_i[CTL_LATCH] && wdata_i[CTL_HV]) |=> !ctrl_q[CTL_LATCH] && !hv)
		else $error("latch and voltage set together");
	a_zero_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_i && addr_i == ADDR_CTRL && wdata_i == 8'h00) |=> ctrl_q == 8'h00)
		else $error("zero write did not clear control");
	a_latch_excl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		shared_ctrl_i && $past(shared_ctrl_i) |-> !(ctrl_q[CTL_LATCH] && ctrl_q[CTL_OTP]))
		else $error("both latch bits set");
	a_guard_lock: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(open_q == OPEN_COUNT && !special_mode_i && clk_en_i) |=>
		((prot_q & $past(prot_q)) == $past(prot_q)))
		else $error("guard cleared after window");
	a_hv_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && wr_i && addr_i == ADDR_CTRL && ctrl_q[CTL_LATCH] && wdata_i[CTL_LATCH])
		|=> hv_on_o == $past(wdata_i[CTL_HV]))
		else $error("voltage output mismatch");
	a_no_read_latched: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(clk_en_i && rd_i && ctrl_q[CTL_LATCH] && bus_in_array) |=> rdata_o == 8'h00)
		else $error("array readable while latched");
	a_opt_guard: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		prot_q[PROT_OPT] |=> $stable(opt_val))
		else $error("options changed while guarded");
	a_secure_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(security_i && !single_chip_i) |-> !modes_ok_o)
		else $error("secure part outside single-chip");

endmodule

// [verification/eepc_tb.sv]
// self-checking bench for the array program/erase controller
`timescale 1ns/10ps
module testbench;
	import eepc_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        en = 1'b1;
	logic        big = 1'b0;
	logic        spc = 1'b0;
	logic        sec = 1'b0;
	logic        sgl = 1'b0;
	logic        shr = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdat = 8'h00;
	logic [7:0]  rdat;
	logic        hv;
	logic        mok;
	logic [7:0]  v;
	logic [15:0] ra;
	logic [31:0] seed = 32'hBF638DC1;
	int          errors = 0;
	int          comparisons = 0;
	logic [15:0] tab [2][8] = '{
		'{16'hB600, 16'hB61F, 16'hB620, 16'hB65F, 16'hB660, 16'hB6DF, 16'hB6E0, 16'hB7FF},
		'{16'hF800, 16'hF9FF, 16'hFA00, 16'hFBFF, 16'hFC00, 16'hFDFF, 16'hFE00, 16'hFFFF}};

	eepc_top eepc_top_i (
		.ref_clk_i      (clk),
		.rst_i          (rst),
		.clk_en_i       (en),
		.big_array_i    (big),
		.special_mode_i (spc),
		.security_i     (sec),
		.single_chip_i  (sgl),
		.shared_ctrl_i  (shr),
		.addr_i         (addr),
		.wdata_i        (wdat),
		.wr_i           (wr),
		.rd_i           (rd),
		.rdata_o        (rdat),
		.hv_on_o        (hv),
		.modes_ok_o     (mok)
	);

	// E clock runs far above 1 MHz, so software leaves the pump on the E clock
	always #12.5 clk = ~clk;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// guard bit index for an address; sizes 32, 64, 128, 288 upward
	function automatic int blk(input logic b, input logic [15:0] a);
		logic [15:0] o;
		o = a - ADDR_ARRAY_STD;
		if (b)
			return int'(a[10:9]);
		return (o < 32) ? 0 : (o < 96) ? 1 : (o < 224) ? 2 : 3;
	endfunction

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	// gap cycle between strobes keeps one assignment per time step
	task automatic wrt(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdb(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask

	task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rdb(a, d);
		chk(n, d, e);
	endtask

	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		wrt(ADDR_CTRL, 8'h02);
		wrt(a, d);
		wrt(ADDR_CTRL, 8'h03);
		wrt(ADDR_CTRL, 8'h00);
	endtask

	// voltage held only a few cycles: the block has no timer of its own
	task automatic ers(input logic [15:0] a, input logic [7:0] c);
		wrt(ADDR_CTRL, c);
		wrt(a, 8'h00);
		wrt(ADDR_CTRL, c | 8'h01);
		wrt(ADDR_CTRL, 8'h00);
	endtask

	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	// whole run needs a little over a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rchk("ctrl reset", ADDR_CTRL, CTRL_RESET);
		rchk("guard reset", ADDR_PROTECT, PROTECT_RESET);
		wrt(ADDR_PROTECT, 8'h00);
		rchk("guard early clear", ADDR_PROTECT, 8'h00);
		wrt(ADDR_CTRL, 8'h03);
		#1 chk("hv together", {7'h0, hv}, 8'h00);
		rchk("ctrl together", ADDR_CTRL, 8'h00);
		ers(16'hB610, 8'h16);
		rchk("byte erased", 16'hB610, ERASED_BYTE);
		wrt(16'hB610, 8'h00);
		rchk("unlatched write", 16'hB610, ERASED_BYTE);
		wrt(ADDR_CTRL, 8'h02);
		wrt(16'hB610, 8'h5A);
		rchk("latched read", 16'hB610, 8'h00);
		wrt(ADDR_CTRL, 8'h03);
		#1 chk("hv on", {7'h0, hv}, 8'h01);
		wrt(ADDR_CTRL, 8'h00);
		#1 chk("hv off", {7'h0, hv}, 8'h00);
		rchk("programmed", 16'hB610, 8'h5A);
		prog(16'hB610, 8'h3C);
		rchk("ones kept", 16'hB610, 8'h18);
		ers(16'hB611, 8'h16);
		rchk("byte bounded", 16'hB610, 8'h18);
		wrt(ADDR_CTRL, 8'h1A);
		wrt(16'hB611, 8'h0F);
		wrt(ADDR_CTRL, 8'h1B);
		wrt(ADDR_CTRL, 8'h00);
		rchk("mode bits ignored", 16'hB611, 8'h0F);
		ers(16'hB620, 8'h16);
		prog(16'hB620, 8'h00);
		ers(16'hB615, 8'h0E);
		rchk("row erased", 16'hB610, ERASED_BYTE);
		rchk("row bounded", 16'hB620, 8'h00);
		ers(ADDR_OPTIONS, 8'h16);
		prog(ADDR_OPTIONS, 8'hF5);
		rchk("options programmed", ADDR_OPTIONS, 8'hF5);
		ers(16'hB7FF, 8'h06);
		rchk("bulk erased", 16'hB620, ERASED_BYTE);
		rchk("options kept", ADDR_OPTIONS, 8'hF5);

		spc <= 1'b1;
		for (int b = 0; b < 2; b++)
			for (int g = 0; g < 4; g++)
			begin
				big <= b[0];
				wrt(ADDR_PROTECT, 8'h00);
				ers(tab[b][0], 8'h06);
				wrt(ADDR_PROTECT, 8'h01 << g);
				for (int i = 0; i < 8; i++)
					prog(tab[b][i], 8'h00);
				for (int i = 0; i < 8; i++)
					rchk("map", tab[b][i], blk(b[0], tab[b][i]) == g ? 8'hFF : 8'h00);
			end
		big <= 1'b0;
		wrt(ADDR_PROTECT, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			ra = ADDR_ARRAY_STD + {7'h0, seed[8:0]};
			ers(ra, 8'h16);
			prog(ra, seed[16:9]);
			prog(ra, seed[31:24]);
			rchk("random program", ra, seed[16:9] & seed[31:24]);
		end

		spc <= 1'b0;
		wrt(ADDR_PROTECT, 8'h1F);
		wrt(ADDR_PROTECT, 8'h00);
		rchk("guard late clear", ADDR_PROTECT, 8'h1F);
		prog(ADDR_OPTIONS, 8'h00);
		rchk("options guarded", ADDR_OPTIONS, 8'hF5);
		shr <= 1'b1;
		wrt(ADDR_CTRL, 8'h22);
		rdb(ADDR_CTRL, v);
		chk("latch exclusive", {7'h0, v[5] & v[1]}, 8'h00);
		wrt(ADDR_CTRL, 8'h00);
		en <= 1'b0;
		wrt(ADDR_CTRL, 8'h02);
		en <= 1'b1;
		rchk("frozen", ADDR_CTRL, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			sec <= i[0];
			sgl <= i[1];
			@(posedge clk);
			#1 chk("modes", {7'h0, mok}, {7'h0, !i[0] | i[1]});
		end
		complete_run();
	end
endmodule
